// ==== psg_defines.svh ====
`ifndef PSG_DEFINES_SVH
`define PSG_DEFINES_SVH

// Suspend and resume opcodes
`define PSG_OP_SUSPEND_A 8'h75
`define PSG_OP_SUSPEND_B 8'hb0
`define PSG_OP_RESUME_A 8'hd0
`define PSG_OP_RESUME_B 8'h7a

// Array reads
`define PSG_OP_READ_03 8'h03
`define PSG_OP_READ_0B 8'h0b
`define PSG_OP_READ_3B 8'h3b
`define PSG_OP_READ_6B 8'h6b
`define PSG_OP_READ_EB 8'heb
`define PSG_OP_READ_E7 8'he7
`define PSG_OP_BUF_READ 8'hd4
`define PSG_OP_LOCK_RD_A 8'h3c
`define PSG_OP_LOCK_RD_B 8'h3d
`define PSG_OP_OTP_READ 8'h4b

// Write enable latch control
`define PSG_OP_WREN 8'h06
`define PSG_OP_WRDI 8'h04
`define PSG_OP_VWREN 8'h50

// Programs allowed in erase suspend
`define PSG_OP_BUF_WRITE 8'h84
`define PSG_OP_PP_02 8'h02
`define PSG_OP_PP_A2 8'ha2
`define PSG_OP_PP_32 8'h32
`define PSG_OP_BUF_PROG 8'h88
`define PSG_OP_SEQ_A 8'had
`define PSG_OP_SEQ_B 8'haf

// Commands allowed in every state
`define PSG_OP_RDSR1 8'h05
`define PSG_OP_RDSR2 8'h35
`define PSG_OP_RDSR3 8'h15
`define PSG_OP_RDSR_IND 8'h65
`define PSG_OP_ACT_INT 8'h25
`define PSG_OP_TERMINATE 8'hf0
`define PSG_OP_RST_EN 8'h66
`define PSG_OP_RST_DEV 8'h99
`define PSG_OP_ID_9F 8'h9f
`define PSG_OP_ID_90 8'h90
`define PSG_OP_ID_94 8'h94
`define PSG_OP_DPD_EXIT 8'hab

// Status register bit positions
`define PSG_SR1_BUSY_BIT 0
`define PSG_SR1_WEL_BIT 1
`define PSG_SR5_ES_BIT 0
`define PSG_SR5_PS_BIT 1

// Opcode framing and block number width
`define PSG_BITS_PER_BYTE 4'h8
`define PSG_BLOCK_W 5

`endif

// ==== psg_pkg.sv ====
package psg_pkg;

    typedef enum logic [1:0] {
        PSG_ST_READY = 2'b00,
        PSG_ST_BUSY = 2'b01,
        PSG_ST_PSUSP = 2'b10,
        PSG_ST_ESUSP = 2'b11
    } psg_state_t;

    typedef enum logic [2:0] {
        PSG_CL_SUSPEND = 3'b000,
        PSG_CL_RESUME = 3'b001,
        PSG_CL_READ = 3'b010,
        PSG_CL_WEL = 3'b011,
        PSG_CL_BUFWR = 3'b100,
        PSG_CL_PROGRAM = 3'b101,
        PSG_CL_ALWAYS = 3'b110,
        PSG_CL_IDLE_ONLY = 3'b111
    } psg_class_t;

endpackage : psg_pkg

// ==== psg_sync.sv ====
`timescale 1ns/1ps

module psg_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // Reset value matches an idle bus: chip select high, clock low
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : psg_sync

// ==== psg_top.sv ====
`timescale 1ns/1ps
`include "psg_defines.svh"

// Function
// - Opcodes 75h and B0h both decode to the same suspend action.
// - Suspend is opcode only; any further clocks cancel it.
// - Suspend starts only when chip select rises after the opcode.
// - Once suspended, permitted reads and programs are accepted.
// - Commands not permitted in the current state are discarded.
// - A rejected command leaves the write enable latch unchanged.
// - Busy sits in status register one, suspend flags in register five.
// - While busy only suspend and harmless commands are accepted.
// - Program suspend accepts reads, resume and write enable controls.
// - Erase suspend also accepts buffer write and program commands.
// - Array reads rejected while busy, accepted in either suspend.
// - Programs in erase suspend must target another 64 kB block.
// - On suspend completion set suspend flags and clear busy.
// - Suspend ignored during cycles that cannot be suspended.
// - Chip select must rise after the full opcode, on a byte boundary.
module psg_top (
    // System
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    // Serial pins from the host
    input wire logic SPI_CS_N_IN,
    input wire logic SPI_SCK_IN,
    input wire logic SPI_SI_IN,
    // Internal program/erase engine events
    input wire logic CYCLE_START_IN,
    input wire logic CYCLE_IS_ERASE_IN,
    input wire logic CYCLE_SUSPENDABLE_IN,
    input wire logic [`PSG_BLOCK_W-1:0] CYCLE_BLOCK_IN,
    input wire logic CYCLE_DONE_IN,
    input wire logic SUSPEND_DONE_IN,
    input wire logic WEL_CLEAR_IN,
    // Target block of an accepted program, once its address is known
    input wire logic CMD_BLOCK_VALID_IN,
    input wire logic [`PSG_BLOCK_W-1:0] CMD_BLOCK_IN,
    // Command gate results
    output logic CMD_ACCEPT_OUT,
    output logic CMD_REJECT_OUT,
    output logic [7:0] CMD_OPCODE_OUT,
    output logic CMD_BLOCK_CHECK_OUT,
    output logic CMD_ABORT_OUT,
    // Requests to the engine
    output logic SUSPEND_REQ_OUT,
    output logic RESUME_REQ_OUT,
    // Status
    output logic [7:0] STATUS_REG1_OUT,
    output logic [7:0] STATUS_REG5_OUT,
    output logic SUSPENDED_SUMMARY_FLAG_OUT
);

    logic [2:0] pins_sync;
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic sck_prev_reg;
    logic cs_n_prev_reg;
    logic [3:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic have_op_reg;
    logic extra_bits_reg;
    logic [7:0] op_reg;
    logic op_ok_reg;
    logic op_in_progress_flag_reg;
    logic program_suspended_flag_reg;
    logic erase_suspended_flag_reg;
    logic suspended_summary_flag_reg;
    logic write_enable_latch_reg;
    logic cyc_erase_reg;
    logic cyc_suspendable_reg;
    logic suspend_wait_reg;
    logic block_check_reg;
    logic [`PSG_BLOCK_W-1:0] suspended_summary_flag_block_reg;

    psg_sync #(.WIDTH(3)) u_sync (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .async_in({SPI_SI_IN, SPI_SCK_IN, ~SPI_CS_N_IN}),
        .sync_out(pins_sync)
    );

    assign cs_n_s = ~pins_sync[0];
    assign sck_s = pins_sync[1];
    assign si_s = pins_sync[2];

    // Mode 0 and 3 both sample on the rising clock edge
    wire sck_rise = sck_s & ~sck_prev_reg & ~cs_n_s;
    wire cs_rise = cs_n_s & ~cs_n_prev_reg;
    wire byte_last = sck_rise & (bit_cnt_reg == 4'h7);
    wire [7:0] op_byte = {shift_reg, si_s};
    wire op_done = byte_last & ~have_op_reg;

    // Derived state
    psg_pkg::psg_state_t state;
    assign state = op_in_progress_flag_reg ? psg_pkg::PSG_ST_BUSY :
                   program_suspended_flag_reg ? psg_pkg::PSG_ST_PSUSP :
                   erase_suspended_flag_reg ? psg_pkg::PSG_ST_ESUSP :
                   psg_pkg::PSG_ST_READY;

    function automatic psg_pkg::psg_class_t classify(input logic [7:0] op);
        unique case (op)
            `PSG_OP_SUSPEND_A, `PSG_OP_SUSPEND_B:
                classify = psg_pkg::PSG_CL_SUSPEND;
            `PSG_OP_RESUME_A, `PSG_OP_RESUME_B:
                classify = psg_pkg::PSG_CL_RESUME;
            `PSG_OP_READ_03, `PSG_OP_READ_0B, `PSG_OP_READ_3B,
            `PSG_OP_READ_6B, `PSG_OP_READ_EB, `PSG_OP_READ_E7,
            `PSG_OP_BUF_READ, `PSG_OP_LOCK_RD_A, `PSG_OP_LOCK_RD_B,
            `PSG_OP_OTP_READ:
                classify = psg_pkg::PSG_CL_READ;
            `PSG_OP_WREN, `PSG_OP_WRDI, `PSG_OP_VWREN:
                classify = psg_pkg::PSG_CL_WEL;
            `PSG_OP_BUF_WRITE:
                classify = psg_pkg::PSG_CL_BUFWR;
            `PSG_OP_PP_02, `PSG_OP_PP_A2, `PSG_OP_PP_32, `PSG_OP_BUF_PROG,
            `PSG_OP_SEQ_A, `PSG_OP_SEQ_B:
                classify = psg_pkg::PSG_CL_PROGRAM;
            `PSG_OP_RDSR1, `PSG_OP_RDSR2, `PSG_OP_RDSR3, `PSG_OP_RDSR_IND,
            `PSG_OP_ACT_INT, `PSG_OP_TERMINATE, `PSG_OP_RST_EN,
            `PSG_OP_RST_DEV, `PSG_OP_ID_9F, `PSG_OP_ID_90, `PSG_OP_ID_94,
            `PSG_OP_DPD_EXIT:
                classify = psg_pkg::PSG_CL_ALWAYS;
            default:
                classify = psg_pkg::PSG_CL_IDLE_ONLY;
        endcase
    endfunction : classify

    psg_pkg::psg_class_t op_class;
    assign op_class = classify(op_byte);

    // Acceptance table per state
    logic allowed;
    always_comb begin
        allowed = 1'b0;
        unique case (state)
            psg_pkg::PSG_ST_BUSY:
                allowed = (op_class == psg_pkg::PSG_CL_ALWAYS) ||
                          ((op_class == psg_pkg::PSG_CL_SUSPEND) &&
                           cyc_suspendable_reg &&
                           !suspend_wait_reg);
            psg_pkg::PSG_ST_PSUSP:
                allowed = (op_class == psg_pkg::PSG_CL_ALWAYS) ||
                          (op_class == psg_pkg::PSG_CL_READ) ||
                          (op_class == psg_pkg::PSG_CL_RESUME) ||
                          (op_class == psg_pkg::PSG_CL_WEL);
            psg_pkg::PSG_ST_ESUSP:
                allowed = (op_class == psg_pkg::PSG_CL_ALWAYS) ||
                          (op_class == psg_pkg::PSG_CL_READ) ||
                          (op_class == psg_pkg::PSG_CL_RESUME) ||
                          (op_class == psg_pkg::PSG_CL_WEL) ||
                          (op_class == psg_pkg::PSG_CL_BUFWR) ||
                          (op_class == psg_pkg::PSG_CL_PROGRAM);
            psg_pkg::PSG_ST_READY:
                allowed = (op_class != psg_pkg::PSG_CL_SUSPEND) &&
                          (op_class != psg_pkg::PSG_CL_RESUME);
        endcase
    end

    // Opcode-only framing: exactly one byte, then chip select high
    wire frame_exact = cs_rise & have_op_reg & op_ok_reg & ~extra_bits_reg &
                       (bit_cnt_reg == 4'h0);
    wire do_suspend = frame_exact &&
                      ((op_reg == `PSG_OP_SUSPEND_A) ||
                       (op_reg == `PSG_OP_SUSPEND_B));
    wire do_resume = frame_exact &&
                     ((op_reg == `PSG_OP_RESUME_A) ||
                      (op_reg == `PSG_OP_RESUME_B));
    wire do_wel_set = frame_exact &&
                      ((op_reg == `PSG_OP_WREN) || (op_reg == `PSG_OP_VWREN));
    wire do_wel_clr = frame_exact && (op_reg == `PSG_OP_WRDI);
    wire block_hit = block_check_reg & CMD_BLOCK_VALID_IN &
                     (CMD_BLOCK_IN == suspended_summary_flag_block_reg);

    // Serial deserialiser; counters reset whenever chip select is high
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            sck_prev_reg <= 1'b0;
            cs_n_prev_reg <= 1'b1;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 7'h00;
            have_op_reg <= 1'b0;
            extra_bits_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_s;
            cs_n_prev_reg <= cs_n_s;
            if (cs_n_s) begin
                bit_cnt_reg <= 4'h0;
                have_op_reg <= 1'b0;
                extra_bits_reg <= 1'b0;
            end else if (sck_rise) begin
                shift_reg <= op_byte[6:0];
                bit_cnt_reg <= byte_last ? 4'h0 : bit_cnt_reg + 4'h1;
                extra_bits_reg <= extra_bits_reg | have_op_reg;
                if (byte_last) begin
                    have_op_reg <= 1'b1;
                end
            end
        end
    end

    // Gate decision, made once per frame on the opcode byte
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            op_reg <= 8'h00;
            op_ok_reg <= 1'b0;
            CMD_OPCODE_OUT <= 8'h00;
            CMD_ACCEPT_OUT <= 1'b0;
            CMD_REJECT_OUT <= 1'b0;
            CMD_ABORT_OUT <= 1'b0;
            block_check_reg <= 1'b0;
        end else begin
            CMD_ACCEPT_OUT <= op_done & allowed;
            CMD_REJECT_OUT <= op_done & ~allowed;
            CMD_ABORT_OUT <= block_hit;
            if (op_done) begin
                op_reg <= op_byte;
                op_ok_reg <= allowed;
                CMD_OPCODE_OUT <= op_byte;
                block_check_reg <= allowed &&
                    (state == psg_pkg::PSG_ST_ESUSP) &&
                    (op_class == psg_pkg::PSG_CL_PROGRAM);
            end else if (cs_rise || block_hit || CMD_BLOCK_VALID_IN) begin
                block_check_reg <= 1'b0;
            end
        end
    end

    assign CMD_BLOCK_CHECK_OUT = block_check_reg;

    // Flags; a cycle start wins over a completion in the same clock
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            op_in_progress_flag_reg <= 1'b0;
            program_suspended_flag_reg <= 1'b0;
            erase_suspended_flag_reg <= 1'b0;
            suspended_summary_flag_reg <= 1'b0;
            write_enable_latch_reg <= 1'b0;
            cyc_erase_reg <= 1'b0;
            cyc_suspendable_reg <= 1'b0;
            suspend_wait_reg <= 1'b0;
            suspended_summary_flag_block_reg <= '0;
            SUSPEND_REQ_OUT <= 1'b0;
            RESUME_REQ_OUT <= 1'b0;
        end else begin
            SUSPEND_REQ_OUT <= do_suspend;
            RESUME_REQ_OUT <= do_resume;
            if (do_suspend) begin
                suspend_wait_reg <= 1'b1;
            end else if (SUSPEND_DONE_IN || CYCLE_DONE_IN) begin
                suspend_wait_reg <= 1'b0;
            end
            if (CYCLE_START_IN) begin
                op_in_progress_flag_reg <= 1'b1;
                cyc_erase_reg <= CYCLE_IS_ERASE_IN;
                cyc_suspendable_reg <= CYCLE_SUSPENDABLE_IN;
                if (CYCLE_IS_ERASE_IN) begin
                    suspended_summary_flag_block_reg <= CYCLE_BLOCK_IN;
                end
            end else if (SUSPEND_DONE_IN && suspend_wait_reg) begin
                op_in_progress_flag_reg <= 1'b0;
                suspended_summary_flag_reg <= 1'b1;
                if (cyc_erase_reg) begin
                    erase_suspended_flag_reg <= 1'b1;
                end else begin
                    program_suspended_flag_reg <= 1'b1;
                end
            end else if (do_resume) begin
                // A suspended program resumes before a suspended erase
                op_in_progress_flag_reg <= 1'b1;
                cyc_suspendable_reg <= 1'b1;
                if (program_suspended_flag_reg) begin
                    program_suspended_flag_reg <= 1'b0;
                    cyc_erase_reg <= 1'b0;
                    suspended_summary_flag_reg <= erase_suspended_flag_reg;
                end else begin
                    erase_suspended_flag_reg <= 1'b0;
                    cyc_erase_reg <= 1'b1;
                    suspended_summary_flag_reg <= 1'b0;
                end
            end else if (CYCLE_DONE_IN) begin
                op_in_progress_flag_reg <= 1'b0;
            end
            // Only accepted commands and WEL_CLEAR_IN touch the latch
            if (do_wel_set) begin
                write_enable_latch_reg <= 1'b1;
            end else if (do_wel_clr || WEL_CLEAR_IN) begin
                write_enable_latch_reg <= 1'b0;
            end
        end
    end

    // Status registers
    always_comb begin
        STATUS_REG1_OUT = 8'h00;
        STATUS_REG5_OUT = 8'h00;
        STATUS_REG1_OUT[`PSG_SR1_BUSY_BIT] = op_in_progress_flag_reg;
        STATUS_REG1_OUT[`PSG_SR1_WEL_BIT] = write_enable_latch_reg;
        STATUS_REG5_OUT[`PSG_SR5_ES_BIT] = erase_suspended_flag_reg;
        STATUS_REG5_OUT[`PSG_SR5_PS_BIT] =
            program_suspended_flag_reg;
    end

    assign SUSPENDED_SUMMARY_FLAG_OUT = suspended_summary_flag_reg;

    // Accepted commands are handed on for the engine to run

endmodule : psg_top

// ==== psg_checker.sv ====
`timescale 1ns/1ps
`include "psg_defines.svh"

module psg_checker (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    // Watched inputs
    input wire logic SPI_CS_N_IN,
    input wire logic CYCLE_START_IN,
    input wire logic CYCLE_DONE_IN,
    input wire logic SUSPEND_DONE_IN,
    input wire logic WEL_CLEAR_IN,
    input wire logic CMD_BLOCK_VALID_IN,
    // Watched outputs
    input wire logic CMD_ACCEPT_OUT,
    input wire logic CMD_REJECT_OUT,
    input wire logic [7:0] CMD_OPCODE_OUT,
    input wire logic CMD_BLOCK_CHECK_OUT,
    input wire logic CMD_ABORT_OUT,
    input wire logic SUSPEND_REQ_OUT,
    input wire logic RESUME_REQ_OUT,
    input wire logic [7:0] STATUS_REG1_OUT,
    input wire logic [7:0] STATUS_REG5_OUT,
    input wire logic SUSPENDED_SUMMARY_FLAG_OUT
);
    logic pend_reg;
    logic pend_next;
    wire logic busy = STATUS_REG1_OUT[`PSG_SR1_BUSY_BIT];
    wire logic write_enable_latch = STATUS_REG1_OUT[`PSG_SR1_WEL_BIT];
    wire logic es = STATUS_REG5_OUT[`PSG_SR5_ES_BIT];
    wire logic ps = STATUS_REG5_OUT[`PSG_SR5_PS_BIT];
    wire logic summ = SUSPENDED_SUMMARY_FLAG_OUT;
    assign pend_next = SUSPEND_REQ_OUT | (pend_reg & ~SUSPEND_DONE_IN);
    always_ff @(posedge CLK_SYS_IN) begin
        pend_reg <= RST_IN ? 1'b0 : pend_next;
    end
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (RST_IN);
    acc_rej_excl_a: assert property (
        !(CMD_ACCEPT_OUT && CMD_REJECT_OUT))
        else $error("accept and reject together");
    req_after_cs_a: assert property (
        SUSPEND_REQ_OUT |-> $past(SPI_CS_N_IN, 2))
        else $error("suspend request before chip select rise");
    req_when_busy_a: assert property (
        SUSPEND_REQ_OUT |-> busy)
        else $error("suspend request while not busy");
    done_clears_a: assert property (
        pend_reg && SUSPEND_DONE_IN && !CYCLE_START_IN && !CYCLE_DONE_IN
        |=> !busy && summ)
        else $error("suspend completion did not update flags");
    summary_match_a: assert property (
        summ == (es || ps))
        else $error("summary flag disagrees with suspend flags");
    resume_busy_a: assert property (
        RESUME_REQ_OUT |-> busy && $past(summ))
        else $error("resume without suspend or busy not set");
    wel_hold_a: assert property (
        CMD_REJECT_OUT && !WEL_CLEAR_IN |=> $stable(write_enable_latch) [*4])
        else $error("write enable changed after reject");
    busy_reads_a: assert property (
        CMD_ACCEPT_OUT && busy |-> !(CMD_OPCODE_OUT inside {8'h03, 8'h0b,
        8'h3b, 8'h6b, 8'heb, 8'he7, 8'hd4, 8'h4b}))
        else $error("read accepted while busy");
    ps_no_prog_a: assert property (
        CMD_ACCEPT_OUT && !busy && ps |-> !(CMD_OPCODE_OUT inside {8'h84,
        8'h02, 8'ha2, 8'h32, 8'h88, 8'had, 8'haf}))
        else $error("program accepted in program suspend");
    no_erase_a: assert property (
        CMD_ACCEPT_OUT && (busy || summ) |-> !(CMD_OPCODE_OUT inside {
        8'h81, 8'hdb, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h58, 8'h0a}))
        else $error("erase accepted while busy or suspended");
    abort_cause_a: assert property (
        CMD_ABORT_OUT |-> $past(CMD_BLOCK_CHECK_OUT)
        && $past(CMD_BLOCK_VALID_IN))
        else $error("abort without block check");
endmodule : psg_checker

bind psg_top psg_checker i_chk (.CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN),
    .SPI_CS_N_IN(SPI_CS_N_IN), .CYCLE_START_IN(CYCLE_START_IN),
    .CYCLE_DONE_IN(CYCLE_DONE_IN), .SUSPEND_DONE_IN(SUSPEND_DONE_IN),
    .WEL_CLEAR_IN(WEL_CLEAR_IN), .CMD_BLOCK_VALID_IN(CMD_BLOCK_VALID_IN),
    .CMD_ACCEPT_OUT(CMD_ACCEPT_OUT), .CMD_REJECT_OUT(CMD_REJECT_OUT),
    .CMD_OPCODE_OUT(CMD_OPCODE_OUT), .CMD_ABORT_OUT(CMD_ABORT_OUT),
    .CMD_BLOCK_CHECK_OUT(CMD_BLOCK_CHECK_OUT),
    .SUSPEND_REQ_OUT(SUSPEND_REQ_OUT), .RESUME_REQ_OUT(RESUME_REQ_OUT),
    .STATUS_REG1_OUT(STATUS_REG1_OUT), .STATUS_REG5_OUT(STATUS_REG5_OUT),
    .SUSPENDED_SUMMARY_FLAG_OUT(SUSPENDED_SUMMARY_FLAG_OUT));

// ==== psg_host.sv ====
`timescale 1ns/1ps

module psg_host (
    // Clock
    input wire logic clk_in,
    // Serial pins towards the device
    output logic cs_n_out,
    output logic sck_out,
    output logic si_out
);
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
    end
    // Mode 0; serial clock stands still between frames
    task automatic frame(input logic [15:0] bits, input int n,
                         input logic keep);
        int i;
        @(negedge clk_in);
        cs_n_out = 1'b0;
        for (i = 0; i < n; i++) begin
            si_out = bits[15-i];
            #32 sck_out = 1'b1;
            #32 sck_out = 1'b0;
        end
        if (!keep) begin
            close();
        end
    endtask : frame
    // Unselected line shows no stale value
    task automatic close();
        #32 cs_n_out = 1'b1;
        si_out = ~si_out;
        repeat (4) @(negedge clk_in);
    endtask : close
endmodule : psg_host

// ==== test_program_erase_suspend_gate.sv ====
`timescale 1ns/1ps
`include "psg_defines.svh"

module test_program_erase_suspend_gate;
    logic clk, rst, cyc_start, cyc_erase, cyc_suspended_summary_flag, cyc_done;
    logic suspended_summary_flag_done, wel_clr, blk_valid, wel_exp;
    logic [4:0] cyc_blk, blk;
    wire logic cs_n, sck, si;
    logic acc, rej, bchk, abort, sreq, rreq, summ;
    logic [7:0] sr1, sr5, sop, opc;
    logic s_acc, s_rej, s_sreq, s_rreq, s_abort;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] rnd = 32'h4f7b;
    logic [7:0] ops [$] = '{8'h05, 8'h35, 8'h15, 8'h65, 8'h25, 8'hf0,
        8'h66, 8'h99, 8'h9f, 8'h90, 8'h94, 8'hab, 8'h75, 8'hb0, 8'hd0,
        8'h7a, 8'h03, 8'h0b, 8'h3b, 8'h6b, 8'heb, 8'he7, 8'hd4, 8'h3c,
        8'h3d, 8'h4b, 8'h06, 8'h04, 8'h50, 8'h84, 8'h02, 8'ha2, 8'h32,
        8'h88, 8'had, 8'haf, 8'h81, 8'hdb, 8'h20, 8'h52, 8'hd8, 8'h60,
        8'hc7, 8'h58, 8'h0a, 8'h36, 8'h39, 8'h7e, 8'h98, 8'h9b, 8'h01,
        8'h31, 8'h11, 8'h71, 8'h6f};

    psg_host i_host (.clk_in(clk), .cs_n_out(cs_n), .sck_out(sck),
        .si_out(si));
    psg_top i_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .SPI_CS_N_IN(cs_n),
        .SPI_SCK_IN(sck), .SPI_SI_IN(si), .CYCLE_START_IN(cyc_start),
        .CYCLE_IS_ERASE_IN(cyc_erase), .CYCLE_SUSPENDABLE_IN(cyc_suspended_summary_flag),
        .CYCLE_BLOCK_IN(cyc_blk), .CYCLE_DONE_IN(cyc_done),
        .SUSPEND_DONE_IN(suspended_summary_flag_done), .WEL_CLEAR_IN(wel_clr),
        .CMD_BLOCK_VALID_IN(blk_valid), .CMD_BLOCK_IN(blk),
        .CMD_ACCEPT_OUT(acc), .CMD_REJECT_OUT(rej), .CMD_OPCODE_OUT(opc),
        .CMD_BLOCK_CHECK_OUT(bchk), .CMD_ABORT_OUT(abort),
        .SUSPEND_REQ_OUT(sreq), .RESUME_REQ_OUT(rreq),
        .STATUS_REG1_OUT(sr1), .STATUS_REG5_OUT(sr5),
        .SUSPENDED_SUMMARY_FLAG_OUT(summ));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Unlisted codes pass only when idle
    function automatic logic allowed(input psg_pkg::psg_state_t st,
                                     input logic [7:0] op);
        case (op)
            8'h05, 8'h35, 8'h15, 8'h65, 8'h25, 8'hf0, 8'h66, 8'h99,
            8'h9f, 8'h90, 8'h94, 8'hab: return 1'b1;
            8'h75, 8'hb0: return st == psg_pkg::PSG_ST_BUSY;
            8'hd0, 8'h7a: return st inside {psg_pkg::PSG_ST_PSUSP,
                psg_pkg::PSG_ST_ESUSP};
            8'h03, 8'h0b, 8'h3b, 8'h6b, 8'heb, 8'he7, 8'hd4, 8'h3c, 8'h3d,
            8'h4b, 8'h06, 8'h04, 8'h50: return st != psg_pkg::PSG_ST_BUSY;
            8'h84, 8'h02, 8'ha2, 8'h32, 8'h88, 8'had, 8'haf:
                return st inside {psg_pkg::PSG_ST_ESUSP, psg_pkg::PSG_ST_READY};
            default: return st == psg_pkg::PSG_ST_READY;
        endcase
    endfunction : allowed

    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic check_bit(input string name, input logic exp,
                             input logic got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit

    task automatic check_byte(input string name, input logic [7:0] exp,
                              input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check_byte

    // Pulses are caught here so none slips past a busy task
    always @(posedge clk) begin
        cycles++;
        if (acc === 1'b1) s_acc = 1'b1;
        if (rej === 1'b1) s_rej = 1'b1;
        if (sreq === 1'b1) s_sreq = 1'b1;
        if (rreq === 1'b1) s_rreq = 1'b1;
        if (abort === 1'b1) s_abort = 1'b1;
        if (cycles == 30000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic clear();
        {s_acc, s_rej, s_sreq, s_rreq, s_abort} = 5'h00;
    endtask : clear

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        repeat (2) @(negedge clk);
    endtask : pulse

    task automatic do_op(input logic [7:0] op, input psg_pkg::psg_state_t st);
        logic ok;
        ok = allowed(st, op);
        clear();
        i_host.frame({op, 8'h00}, 8, 1'b0);
        repeat (8) @(negedge clk);
        check_bit("accept", ok, s_acc);
        check_bit("reject", !ok, s_rej);
        check_byte("opcode", op, opc);
        if (ok && op inside {8'h06, 8'h50}) wel_exp = 1'b1;
        if (ok && op == 8'h04) wel_exp = 1'b0;
        check_bit("wel", wel_exp, sr1[`PSG_SR1_WEL_BIT]);
    endtask : do_op

    task automatic sweep(input psg_pkg::psg_state_t st);
        int i;
        logic [7:0] op;
        logic bsy;
        rnd = lfsr(rnd);
        bsy = st == psg_pkg::PSG_ST_BUSY;
        for (i = 0; i < ops.size(); i++) begin
            op = ops[(i + rnd[7:0]) % ops.size()];
            if (bsy ? !(op inside {8'h75, 8'hb0}) : !(op inside {8'hd0, 8'h7a}))
                do_op(op, st);
        end
    endtask : sweep

    task automatic cycle(input logic erase, input logic suspended_summary_flag);
        cyc_erase = erase;
        cyc_suspended_summary_flag = suspended_summary_flag;
        pulse(cyc_start);
        check_bit("busy", 1'b1, sr1[`PSG_SR1_BUSY_BIT]);
    endtask : cycle

    task automatic suspend(input logic [7:0] op, input logic erase);
        cycle(erase, 1'b1);
        clear();
        i_host.frame({op, 8'h00}, 8, 1'b1);
        repeat (8) @(negedge clk);
        check_bit("accept", 1'b1, s_acc);
        check_bit("early request", 1'b0, s_sreq);
        i_host.close();
        repeat (8) @(negedge clk);
        check_bit("suspend request", 1'b1, s_sreq);
        pulse(suspended_summary_flag_done);
        check_bit("busy", 1'b0, sr1[`PSG_SR1_BUSY_BIT]);
        check_bit("es", erase, sr5[`PSG_SR5_ES_BIT]);
        check_bit("ps", !erase, sr5[`PSG_SR5_PS_BIT]);
        check_bit("summary", 1'b1, summ);
    endtask : suspend

    task automatic resume(input logic [7:0] op, input psg_pkg::psg_state_t st);
        do_op(op, st);
        check_bit("resume request", 1'b1, s_rreq);
        check_bit("busy", 1'b1, sr1[`PSG_SR1_BUSY_BIT]);
        check_byte("sr5", 8'h00, sr5);
        pulse(cyc_done);
    endtask : resume

    initial begin
        {rst, cyc_start, cyc_erase, cyc_suspended_summary_flag, cyc_done} = 5'h10;
        {suspended_summary_flag_done, wel_clr, blk_valid, wel_exp} = 4'h0;
        {cyc_blk, blk} = 10'h000;
        clear();
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check_byte("sr1", 8'h00, sr1);
        check_byte("sr5", 8'h00, sr5);
        do_op(8'h06, psg_pkg::PSG_ST_READY);
        rnd = lfsr(rnd);
        cyc_blk = rnd[4:0];
        sop = rnd[0] ? 8'h75 : 8'hb0;
        cycle(1'b1, 1'b1);
        sweep(psg_pkg::PSG_ST_BUSY);
        repeat (3) begin
            rnd = lfsr(rnd);
            clear();
            i_host.frame({8'h75, rnd[15:8]}, (rnd[3] ? 1 : 9) + rnd[2:0] % 7,
                1'b0);
            repeat (8) @(negedge clk);
            check_bit("partial request", 1'b0, s_sreq);
        end
        pulse(cyc_done);
        suspend(sop, 1'b1);
        sweep(psg_pkg::PSG_ST_ESUSP);
        for (int i = 0; i < 2; i++) begin
            clear();
            i_host.frame({8'h02, 8'h00}, 8, 1'b1);
            repeat (8) @(negedge clk);
            check_bit("block check", 1'b1, bchk);
            blk = cyc_blk + i[4:0];
            pulse(blk_valid);
            check_bit("abort", i == 0, s_abort);
            i_host.close();
        end
        resume(8'hd0, psg_pkg::PSG_ST_ESUSP);
        suspend(sop ^ 8'hc5, 1'b0);
        sweep(psg_pkg::PSG_ST_PSUSP);
        resume(8'h7a, psg_pkg::PSG_ST_PSUSP);
        cycle(1'b0, 1'b0);
        clear();
        i_host.frame({8'hb0, 8'h00}, 8, 1'b0);
        repeat (8) @(negedge clk);
        check_bit("ignored request", 1'b0, s_sreq);
        pulse(cyc_done);
        pulse(wel_clr);
        check_bit("wel", 1'b0, sr1[`PSG_SR1_WEL_BIT]);
        test_done();
    end
endmodule : test_program_erase_suspend_gate
